// [eeprom_pkg.sv]
// Constants, timing and state encoding for the serial EEPROM write path.
// Assumes a 40 MHz system clock and an 80 ns link sampling clock.
package eeprom_pkg;
	localparam int CLK_PERIOD_NS  = 25;
	localparam int LINK_PERIOD_NS = 80;
	// Noise suppression: glitch_reject_time, in ns
	localparam int GLITCH_NS      = 50;
	// One less than the link samples that must agree before a level is taken
	localparam int GLITCH_CYCLES  = (GLITCH_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
	// Highest slave_clock_rate, in kHz
	localparam int SCL_MAX_KHZ    = 400;
	localparam int WRITE_CYCLE_MS = 10;
	// Longest time, so rounded down
	localparam int unsigned WRITE_CYCLES = WRITE_CYCLE_MS * 1000000 / CLK_PERIOD_NS;

	localparam int ADDR_W     = 12;
	localparam int PAGE_W     = 4;
	localparam int PAGE_BYTES = 16;
	localparam int MEM_WORDS  = 4096;

	localparam logic [3:0] LAST_DATA_BIT = 4'h7;
	localparam logic [3:0] ACK_BIT       = 4'h8;
	localparam logic [4:0] PAGE_FULL     = 5'h10;
	// Device type code: value is arbitrary
	localparam logic [3:0] DEVICE_CODE   = 4'h5;
	// select_bit_two, select_bit_one, select_bit_zero
	localparam logic [2:0] SELECT_BITS   = 3'h0;
	localparam logic       DIR_WRITE     = 1'b0;
	localparam logic       PIN_IDLE      = 1'b1;

	typedef enum logic [2:0] {
		ST_IDLE   = 3'h0,
		ST_DEV    = 3'h1,
		ST_AHI    = 3'h3,
		ST_ALO    = 3'h2,
		ST_DATA   = 3'h6,
		ST_IGNORE = 3'h7
	} linkState_t;
endpackage : eeprom_pkg

// [serial_eeprom_slave.sv]
// Two-wire slave write path of a 4k x 8 EEPROM with self-timed programming.
// Assumes an external pull-up on SDA; linkClk is a free-running sampling clock.
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_slave
	import eeprom_pkg::*;
#(
	parameter int unsigned writeCycleCount = WRITE_CYCLES
) (
	input  wire logic              clk,
	input  wire logic              reset_n,
	input  wire logic              linkClk,
	input  wire logic              sclIn,
	input  wire logic              sdaIn,
	output logic                   sdaOut,
	output logic                   sdaOe,
	input  wire logic              wpIn,
	input  wire logic [ADDR_W-1:0] rdAddr,
	output logic      [7:0]        rdData,
	output logic                   writeBusy
);
	// ---------------- Link domain ----------------
	logic [1:0]              pinRaw;
	logic [1:0]              filt;
	logic                    sclF;
	logic                    sdaF;
	logic                    sclPrevR;
	logic                    sdaPrevR;
	logic                    sclRise;
	logic                    sclFall;
	logic                    startEv;
	logic                    stopEv;
	logic                    byteEnd;
	logic [7:0]              newByte;
	logic                    addrMatch;
	logic                    linkBusy;
	logic                    canLaunch;
	logic                    wpS1;
	logic                    wpSync;
	logic                    doneS1;
	logic                    doneS2;
	logic                    doneTglR;
	logic                    reqTglR;
	linkState_t              stateR;
	linkState_t              stateNxt;
	logic                    ackWantR;
	logic                    ackWantNxt;
	logic [3:0]              bitCntR;
	logic [7:0]              shiftR;
	logic [3:0]              addrHiR;
	logic [ADDR_W-1:0]       baseAddrR;
	logic [PAGE_W-1:0]       pageOffR;
	logic [4:0]              countR;
	logic [PAGE_BYTES-1:0]   validR;
	logic [7:0]              pageBufR [PAGE_BYTES];

	assign pinRaw = {sdaIn, sclIn};

	// Two-flop sync, then a level is taken only once all recent samples agree
	for (genvar i = 0; i < 2; i++) begin : g_pin
		logic                   s1;
		logic                   s2;
		logic                   fR;
		logic [GLITCH_CYCLES:0] hist;
		always_ff @(posedge linkClk or negedge reset_n) begin
			if (!reset_n) begin
				s1   <= PIN_IDLE;
				s2   <= PIN_IDLE;
				hist <= '1;
				fR   <= PIN_IDLE;
			end else begin
				s1   <= pinRaw[i];
				s2   <= s1;
				hist <= {hist[GLITCH_CYCLES-1:0], s2};
				if (&hist)
					fR <= 1'b1;
				else if (~|hist)
					fR <= 1'b0;
			end
		end
		assign filt[i] = fR;
	end

	// 80 ns sampling leaves over 15 samples per 400 kHz half period
	assign sclF      = filt[0];
	assign sdaF      = filt[1];
	assign sclRise   = sclF & ~sclPrevR;
	assign sclFall   = ~sclF & sclPrevR;
	assign startEv   = sclF & sclPrevR & sdaPrevR & ~sdaF;
	assign stopEv    = sclF & sclPrevR & ~sdaPrevR & sdaF;
	assign byteEnd   = sclRise & (bitCntR == LAST_DATA_BIT);
	assign newByte   = {shiftR[6:0], sdaF};
	assign addrMatch = (newByte[7:1] == {DEVICE_CODE, SELECT_BITS});
	assign linkBusy  = reqTglR ^ doneS2;
	assign canLaunch = stopEv & (stateR == ST_DATA) & (countR != 5'h0) & ~wpSync;
	// Open drain: only ever pulls low
	assign sdaOut    = 1'b0;

	always_comb begin
		stateNxt   = stateR;
		ackWantNxt = ackWantR;
		if (startEv) begin
			stateNxt   = ST_DEV;
			ackWantNxt = 1'b0;
		end else if (stopEv) begin
			stateNxt   = ST_IDLE;
			ackWantNxt = 1'b0;
		end else if (byteEnd) begin
			case (stateR)
				ST_DEV: begin
					if (addrMatch && !linkBusy) begin
						ackWantNxt = 1'b1;
						stateNxt   = (newByte[0] == DIR_WRITE) ? ST_AHI : ST_IGNORE;
					end else begin
						ackWantNxt = 1'b0;
						stateNxt   = ST_IGNORE;
					end
				end
				ST_AHI: begin
					ackWantNxt = 1'b1;
					stateNxt   = ST_ALO;
				end
				ST_ALO: begin
					ackWantNxt = 1'b1;
					stateNxt   = ST_DATA;
				end
				ST_DATA: begin
					ackWantNxt = 1'b1;
				end
				default: begin
					ackWantNxt = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge linkClk or negedge reset_n) begin
		if (!reset_n) begin
			sclPrevR <= PIN_IDLE;
			sdaPrevR <= PIN_IDLE;
			stateR   <= ST_IDLE;
			ackWantR <= 1'b0;
			bitCntR  <= 4'h0;
			shiftR   <= 8'h00;
			sdaOe    <= 1'b0;
			wpS1     <= 1'b0;
			wpSync   <= 1'b0;
			doneS1   <= 1'b0;
			doneS2   <= 1'b0;
			reqTglR  <= 1'b0;
		end else begin
			sclPrevR <= sclF;
			sdaPrevR <= sdaF;
			stateR   <= stateNxt;
			ackWantR <= ackWantNxt;
			wpS1     <= wpIn;
			wpSync   <= wpS1;
			doneS1   <= doneTglR;
			doneS2   <= doneS1;
			if (startEv)
				bitCntR <= 4'h0;
			else if (sclRise)
				bitCntR <= (bitCntR == ACK_BIT) ? 4'h0 : bitCntR + 4'h1;
			if (sclRise && bitCntR != ACK_BIT)
				shiftR <= newByte;
			if (startEv || stopEv)
				sdaOe <= 1'b0;
			else if (sclFall)
				sdaOe <= (bitCntR == ACK_BIT) & ackWantR;
			if (canLaunch)
				reqTglR <= ~reqTglR;
		end
	end

	// Page capture; contents stay still while the other domain copies them
	always_ff @(posedge linkClk or negedge reset_n) begin
		if (!reset_n) begin
			addrHiR   <= 4'h0;
			baseAddrR <= '0;
			pageOffR  <= '0;
			countR    <= 5'h0;
			validR    <= '0;
		end else if (byteEnd && !startEv && !stopEv) begin
			if (stateR == ST_AHI)
				addrHiR <= newByte[3:0];
			if (stateR == ST_ALO) begin
				baseAddrR <= {addrHiR, newByte};
				pageOffR  <= newByte[PAGE_W-1:0];
				countR    <= 5'h0;
				validR    <= '0;
			end
			if (stateR == ST_DATA) begin
				validR[pageOffR] <= 1'b1;
				pageOffR         <= pageOffR + 4'h1;
				if (countR != PAGE_FULL)
					countR <= countR + 5'h1;
			end
		end
	end

	always_ff @(posedge linkClk) begin
		if (byteEnd && stateR == ST_DATA)
			pageBufR[pageOffR] <= newByte;
	end

	// ---------------- System domain ----------------
	logic              reqS1;
	logic              reqS2;
	logic              reqS3;
	logic              progActiveR;
	logic [4:0]        progIdxR;
	logic [31:0]       timerR;
	logic [7:0]        rdDataR;
	logic [3:0]        writeIdx;
	logic              memWrite;
	logic              timerEnd;
	logic [7:0]        mem [MEM_WORDS];

	assign writeIdx  = progIdxR[3:0];
	assign memWrite  = progActiveR & ~progIdxR[4] & validR[writeIdx];
	assign timerEnd  = (timerR == 32'(writeCycleCount - 1));
	assign writeBusy = progActiveR;
	assign rdData    = rdDataR;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			reqS1       <= 1'b0;
			reqS2       <= 1'b0;
			reqS3       <= 1'b0;
			doneTglR    <= 1'b0;
			progActiveR <= 1'b0;
			progIdxR    <= 5'h0;
			timerR      <= '0;
		end else begin
			reqS1 <= reqTglR;
			reqS2 <= reqS1;
			reqS3 <= reqS2;
			if (reqS2 ^ reqS3) begin
				progActiveR <= 1'b1;
				progIdxR    <= 5'h0;
				timerR      <= '0;
			end else if (progActiveR) begin
				timerR <= timerR + 32'h1;
				if (!progIdxR[4])
					progIdxR <= progIdxR + 5'h1;
				if (timerEnd) begin
					progActiveR <= 1'b0;
					doneTglR    <= ~doneTglR;
				end
			end
		end
	end

	// Bytes land at their page offsets in the aligned 16-byte page, so the first byte goes where it was addressed
	always_ff @(posedge clk) begin
		if (memWrite)
			mem[{baseAddrR[ADDR_W-1:PAGE_W], writeIdx}] <= pageBufR[writeIdx];
		rdDataR <= mem[rdAddr];
	end

	// ---------------- Checks ----------------
	sequence s_ackClock;
		sclFall && (bitCntR == ACK_BIT) && ackWantR;
	endsequence
	sequence s_badAddress;
		byteEnd && !startEv && !stopEv && (stateR == ST_DEV) && !addrMatch;
	endsequence

	a_ack_drive: assert property (@(posedge linkClk) disable iff (!reset_n)
		s_ackClock |=> sdaOe) else $error("ack not driven on ninth clock");
	a_oe_on_fall: assert property (@(posedge linkClk) disable iff (!reset_n)
		$rose(sdaOe) |-> $past(sclFall)) else $error("sda driven outside scl low");
	a_busy_noack: assert property (@(posedge linkClk) disable iff (!reset_n)
		(byteEnd && stateR == ST_DEV && linkBusy && !startEv && !stopEv) |=> !ackWantR ##1 !sdaOe)
		else $error("acknowledged while programming");
	a_start_enter: assert property (@(posedge linkClk) disable iff (!reset_n)
		startEv |=> (stateR == ST_DEV) && (bitCntR == 4'h0)) else $error("start not taken");
	a_stop_idle: assert property (@(posedge linkClk) disable iff (!reset_n)
		stopEv |=> (stateR == ST_IDLE) && !sdaOe) else $error("stop not taken");
	a_stop_launch: assert property (@(posedge linkClk) disable iff (!reset_n)
		canLaunch |=> (reqTglR != $past(reqTglR)) && linkBusy) else $error("no launch on stop");
	a_wp_block: assert property (@(posedge linkClk) disable iff (!reset_n)
		(stopEv && wpSync) |=> $stable(reqTglR)) else $error("write under protect");
	a_addr_miss: assert property (@(posedge linkClk) disable iff (!reset_n)
		s_badAddress |=> !ackWantR && (stateR == ST_IGNORE)) else $error("mismatch acknowledged");
	a_page_wrap: assert property (@(posedge linkClk) disable iff (!reset_n)
		(byteEnd && stateR == ST_DATA && !startEv && !stopEv) |=>
		(pageOffR == $past(pageOffR) + 4'h1) && (baseAddrR == $past(baseAddrR)))
		else $error("page offset step wrong");
	a_msb_first: assert property (@(posedge linkClk) disable iff (!reset_n)
		(sclRise && bitCntR != ACK_BIT) |=> shiftR[0] == $past(sdaF)) else $error("bit order");
	a_write_time: assert property (@(posedge clk) disable iff (!reset_n)
		(progActiveR && timerEnd && !(reqS2 ^ reqS3)) |=> !progActiveR)
		else $error("write cycle overran");
endmodule : serial_eeprom_slave
`default_nettype wire

// [bus_master_model.sv]
// Behavioural two-wire bus master: drives SCL, pulls or releases SDA.
// Assumes an SDA pull-up outside and a 25 ns clock pacing every phase.
`timescale 1ns/1ps
`default_nettype none
module bus_master_model #(
	parameter int phaseClks = 25
) (
	input  wire logic clk,
	input  wire logic sdaBus,
	output var logic  sclOut,
	output var logic  sdaRel
);
	logic glitchOn;
	initial begin
		sclOut   = 1'b1;
		sdaRel   = 1'b1;
		glitchOn = 1'b0;
	end
	task automatic waitPh(input int n);
		repeat (n * phaseClks) @(posedge clk);
	endtask : waitPh
	// Data moves with SCL low, except the one-clock glitchOn pulse in SCL high; sampled late in SCL high
	task automatic bitXfer(input logic b, output logic seen);
		sdaRel <= b;
		waitPh(1);
		sclOut <= 1'b1;
		waitPh(1);
		if (glitchOn) begin
			sdaRel <= ~b;
			@(posedge clk);
			sdaRel <= b;
		end
		waitPh(1);
		seen = sdaBus;
		sclOut <= 1'b0;
		waitPh(1);
	endtask : bitXfer
	task automatic startCond();
		sdaRel <= 1'b1;
		waitPh(1);
		sclOut <= 1'b1;
		waitPh(1);
		sdaRel <= 1'b0;
		waitPh(1);
		sclOut <= 1'b0;
		waitPh(1);
	endtask : startCond
	task automatic stopCond();
		sdaRel <= 1'b0;
		waitPh(1);
		sclOut <= 1'b1;
		waitPh(1);
		sdaRel <= 1'b1;
		waitPh(2);
	endtask : stopCond
	// Ninth clock released so the slave can answer
	task automatic sendByte(input logic [7:0] b, output logic ack);
		logic d;
		for (int i = 7; i >= 0; i--) begin
			bitXfer(b[i], d);
		end
		bitXfer(1'b1, d);
		ack = ~d;
	endtask : sendByte
endmodule : bus_master_model
`default_nettype wire

// [serial_eeprom_slave_tb_top.sv]
// Self-checking bench for the serial EEPROM write path.
// Assumes the bus master model file; SDA is a pulled-up wired level.
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_slave_tb_top;
	import eeprom_pkg::*;
	// Short programming time so a poll fits inside it
	localparam int unsigned cycles = 4000;
	localparam logic [7:0] DEV_W = {DEVICE_CODE, SELECT_BITS, DIR_WRITE};
	logic              clk, linkClk, reset_n, wpIn, sdaOut, sdaOe, writeBusy, sclM, sdaM;
	logic [ADDR_W-1:0] rdAddr;
	logic [7:0]        rdData;
	int                miscompares, checked;
	wire logic         sdaWire;
	assign sdaWire = (sdaOe ? sdaOut : PIN_IDLE) & sdaM;

	serial_eeprom_slave #(.writeCycleCount(cycles)) DUT (.clk(clk), .reset_n(reset_n),
		.linkClk(linkClk), .sclIn(sclM), .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe),
		.wpIn(wpIn), .rdAddr(rdAddr), .rdData(rdData), .writeBusy(writeBusy));
	bus_master_model m (.clk(clk), .sdaBus(sdaWire), .sclOut(sclM), .sdaRel(sdaM));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		linkClk = 1'b0;
		#7;
		forever #40 linkClk = ~linkClk;
	end
	task automatic close_out();
		$display("miscompares=%0d checked=%0d", miscompares, checked);
		if (miscompares == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : close_out
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string msg);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: %s", $time, msg);
		end
	endtask : chk
	task automatic sendChk(input logic [7:0] b, input logic expAck);
		logic a;
		m.sendByte(b, a);
		chk({7'h0, a}, {7'h0, expAck}, "acknowledge");
	endtask : sendChk
	// Upper four address bits are don't-care, so fill them
	task automatic writeSeq(input logic [11:0] a, input int n, input logic [7:0] d0);
		m.startCond();
		sendChk(DEV_W, 1'b1);
		sendChk({4'ha, a[11:8]}, 1'b1);
		sendChk(a[7:0], 1'b1);
		for (int k = 0; k < n; k++) begin
			sendChk(d0 + 8'(k), 1'b1);
		end
		m.stopCond();
	endtask : writeSeq
	task automatic waitBusy();
		repeat (40) begin
			@(posedge clk);
			if (writeBusy === 1'b1) break;
		end
		chk({7'h0, writeBusy}, 8'h1, "programming not launched");
	endtask : waitBusy
	// Polls must be refused while busy, then answered
	task automatic pollDone();
		logic a;
		int   tries;
		tries = 0;
		do begin
			m.startCond();
			m.sendByte(DEV_W, a);
			tries++;
		end while (a !== 1'b1 && tries < 20);
		m.stopCond();
		chk({7'h0, a}, 8'h1, "poll never answered");
		chk(8'(tries > 1), 8'h1, "poll answered while busy");
		chk({7'h0, writeBusy}, 8'h0, "busy after poll answer");
	endtask : pollDone
	task automatic memChk(input logic [11:0] a, input logic [7:0] e);
		rdAddr <= a;
		repeat (2) @(posedge clk);
		chk(rdData, e, "array content");
	endtask : memChk
	task automatic t_byte();
		writeSeq(12'h345, 1, 8'ha7);
		waitBusy();
		pollDone();
		memChk(12'h345, 8'ha7);
	endtask : t_byte
	// 18 bytes from offset e: wraps, last two overwrite
	task automatic t_page();
		int k;
		m.glitchOn = 1'b1;
		writeSeq(12'h5ae, 18, 8'h10);
		m.glitchOn = 1'b0;
		waitBusy();
		pollDone();
		for (int o = 0; o < 16; o++) begin
			k = (o + 2) % 16;
			if (k < 2) k += 16;
			memChk({8'h5a, 4'(o)}, 8'h10 + 8'(k));
		end
	endtask : t_page
	task automatic t_addr();
		for (int i = 0; i < 8; i++) begin
			m.startCond();
			sendChk(DEV_W ^ (8'h1 << i), i == 0);
			m.stopCond();
		end
		// Read after another slave: dummy write, repeated start, read address
		m.startCond();
		sendChk(DEV_W, 1'b1);
		sendChk(8'h03, 1'b1);
		sendChk(8'h45, 1'b1);
		m.startCond();
		sendChk(DEV_W | 8'h01, 1'b1);
		m.stopCond();
		repeat (60) @(posedge clk);
		chk({7'h0, writeBusy}, 8'h0, "dummy write launched");
		chk({7'h0, sdaOut}, 8'h0, "sda output not low");
	endtask : t_addr
	task automatic t_protect();
		wpIn <= 1'b1;
		writeSeq(12'h345, 1, 8'h5c);
		repeat (60) @(posedge clk);
		chk({7'h0, writeBusy}, 8'h0, "protected write launched");
		wpIn <= 1'b0;
		writeSeq(12'h345, 0, 8'h00);
		repeat (60) @(posedge clk);
		chk({7'h0, writeBusy}, 8'h0, "write without data launched");
		memChk(12'h345, 8'ha7);
	endtask : t_protect

	initial begin
		miscompares = 0;
		checked     = 0;
		reset_n     = 1'b0;
		wpIn        = 1'b0;
		rdAddr      = '0;
		repeat (4) @(posedge clk);
		reset_n <= 1'b1;
		repeat (20) @(posedge clk);
		t_byte();
		t_page();
		t_addr();
		t_protect();
		close_out();
	end
	// Tests take near 1.3 ms; 2 ms means a hang
	initial begin
		#2000000;
		miscompares++;
		close_out();
	end
endmodule : serial_eeprom_slave_tb_top
`default_nettype wire
